// ===== rtl/sock_fsm_params.svh
// Offsets, codes, field positions and timing counts of the socket state block
`ifndef SOCK_FSM_PARAMS_SVH
`define SOCK_FSM_PARAMS_SVH

// ==========================================================
// Register word indices; byte address is the index times four
`define IDX_SOURCE_PORT     16'h820a
`define IDX_STATE_CODE      16'h8208
`define IDX_COMMAND         16'h8200
`define IDX_MODE            16'h8201
`define IDX_INT_FLAGS       16'h8202
`define IDX_DEST_IP         16'h8214
`define IDX_EVENTS          16'h8203
`define ADDR_OF(i)          ({(i), 2'b00})
`define SOURCE_PORT_RESET   16'h0000

// ==========================================================
// Status codes
`define CODE_RELEASED       8'h00
`define CODE_ARP            8'h01
`define CODE_TCP_OPENED     8'h13
`define CODE_LISTEN         8'h14
`define CODE_REQ_SENT       8'h15
`define CODE_REQ_RECV       8'h16
`define CODE_CONNECTED      8'h17
`define CODE_CLOSING_WAIT   8'h18
`define CODE_LINGER         8'h1b
`define CODE_CLOSE_WAIT     8'h1c
`define CODE_FINAL_ACK      8'h1d
`define CODE_DATAGRAM       8'h22
`define CODE_RAW_IP         8'h32

// ==========================================================
// Commands and modes
`define CMD_OPEN            8'h01
`define CMD_LISTEN          8'h02
`define CMD_CONNECT         8'h04
`define CMD_DISCON          8'h08
`define CMD_CLOSE           8'h10
`define CMD_SEND            8'h20
`define MODE_TCP            4'h1
`define MODE_UDP            4'h2
`define MODE_IPRAW          4'h3

// ==========================================================
// Interrupt flag and event bit positions
`define INT_TIMEOUT_BIT     3
`define INT_DISCON_BIT      1
`define INT_CON_BIT         0
`define EV_SYNACK_RX        0
`define EV_SYN_RX           1
`define EV_SYNACK_TX_DONE   2
`define EV_ACCEPT_FAIL      3
`define EV_FIN_RX           4
`define EV_DISCON_DONE      5
`define EV_TCP_TIMEOUT      6
`define EV_ARP_REPLY        7
`define EV_ARP_TIMEOUT      8
`define EV_FIN_SENT_ACKED   9
`define EV_WIDTH            10

// ==========================================================
// Timing
`define LINGER_TIME_NS      1000
`define CLK_PERIOD_NS       8
`define LINGER_CYCLES       ((`LINGER_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ===== rtl/sock_fsm_pkg.sv
// Types shared by the socket state block
package sock_fsm_pkg;

	typedef enum logic [3:0] {
		st_released, st_tcp_opened, st_listen, st_req_sent, st_req_recv,
		st_connected, st_close_wait, st_closing_wait, st_linger,
		st_final_ack, st_arp, st_datagram, st_raw_ip
	} sock_state_t;

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [17:0] paddr;
		logic [31:0] pwdata;
	} apb_req_t;

	typedef struct packed {
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
	} apb_rsp_t;

	typedef struct packed {
		logic        arp_request;
		logic        syn_tx;
		logic        synack_tx;
		logic        fin_tx;
		logic        port_valid;
	} net_action_t;

endpackage : sock_fsm_pkg

// ===== rtl/sock_fsm.sv
// Socket transient state machine with APB register slave
`timescale 1ns/1ps
`default_nettype none
`include "sock_fsm_params.svh"

module sock_fsm
	import sock_fsm_pkg::*;
#(
	parameter int LINGER_CYCLES = `LINGER_CYCLES
) (
	input  wire logic                  pclk,
	input  wire logic                  presetn,
	input  wire apb_req_t              apb_req,
	output var  apb_rsp_t              apb_rsp,
	input  wire logic [`EV_WIDTH-1:0]  net_event,
	output var  net_action_t           net_action,
	output var  logic [15:0]           source_port_out
);

	// ==========================================================
	// State
	sock_state_t  state_r, state_nxt;
	sock_state_t  arp_return_r;
	logic [15:0]  socket_source_port_r;
	logic [3:0]   mode_r;
	logic [7:0]   socket_interrupt_flags_r;
	logic [31:0]  socket_dest_ip_r;
	logic [31:0]  resolved_ip_r;
	logic         resolved_valid_r;
	logic [7:0]   cmd;
	logic         cmd_valid;
	logic         timeout_set;
	logic         con_set;
	logic         discon_set;
	logic [15:0]  linger_cnt_r;
	logic         wr_en;
	logic [15:0]  widx;
	logic         setup_phase;

	function automatic logic [7:0] code_of(input sock_state_t s);
		case (s)
			st_tcp_opened:   code_of = `CODE_TCP_OPENED;
			st_listen:       code_of = `CODE_LISTEN;
			st_req_sent:     code_of = `CODE_REQ_SENT;
			st_req_recv:     code_of = `CODE_REQ_RECV;
			st_connected:    code_of = `CODE_CONNECTED;
			st_close_wait:   code_of = `CODE_CLOSE_WAIT;
			st_closing_wait: code_of = `CODE_CLOSING_WAIT;
			st_linger:       code_of = `CODE_LINGER;
			st_final_ack:    code_of = `CODE_FINAL_ACK;
			st_arp:          code_of = `CODE_ARP;
			st_datagram:     code_of = `CODE_DATAGRAM;
			st_raw_ip:       code_of = `CODE_RAW_IP;
			default:         code_of = `CODE_RELEASED;
		endcase
	endfunction : code_of

	// TCP and UDP sockets carry a port; raw IP ignores it
	function automatic logic port_in_use(input logic [3:0] m);
		port_in_use = (m == `MODE_TCP) || (m == `MODE_UDP);
	endfunction : port_in_use

	// Used by the write error path only; the read path decodes the same indices itself
	function automatic logic reg_mapped(input logic [15:0] idx);
		if (idx == `IDX_SOURCE_PORT || idx == `IDX_STATE_CODE || idx == `IDX_MODE) begin
			reg_mapped = 1'b1;
		end else if (idx == `IDX_COMMAND || idx == `IDX_INT_FLAGS || idx == `IDX_DEST_IP) begin
			reg_mapped = 1'b1;
		end else begin
			reg_mapped = 1'b0;
		end
	endfunction : reg_mapped

	// ==========================================================
	// Bus decode
	assign wr_en     = apb_req.psel && apb_req.penable && apb_req.pwrite && apb_rsp.pready;
	assign widx      = apb_req.paddr[17:2];
	assign setup_phase = apb_req.psel && !apb_req.penable;
	assign cmd_valid = wr_en && (widx == `IDX_COMMAND);
	assign cmd       = apb_req.pwdata[7:0];

	// Slave answers one cycle after setup: pready registered on setup
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			apb_rsp <= '0;
		end else begin
			apb_rsp.pready  <= setup_phase;
			apb_rsp.pslverr <= 1'b0;
			apb_rsp.prdata  <= 32'h0000_0000;
			if (setup_phase && !apb_req.pwrite) begin
				if (widx == `IDX_SOURCE_PORT) begin
					apb_rsp.prdata <= {16'h0000, socket_source_port_r};
				end else if (widx == `IDX_STATE_CODE) begin
					apb_rsp.prdata <= {24'h000000, code_of(state_r)};
				end else if (widx == `IDX_MODE) begin
					apb_rsp.prdata <= {28'h0000000, mode_r};
				end else if (widx == `IDX_INT_FLAGS) begin
					apb_rsp.prdata <= {24'h000000, socket_interrupt_flags_r};
				end else if (widx == `IDX_DEST_IP) begin
					apb_rsp.prdata <= socket_dest_ip_r;
				end else if (widx != `IDX_COMMAND) begin
					apb_rsp.pslverr <= 1'b1;
				end
			end else if (setup_phase) begin
				// Status code writes are dropped quietly, not refused
				if (!reg_mapped(widx)) begin
					apb_rsp.pslverr <= 1'b1;
				end
			end
		end
	end

	// ==========================================================
	// Software registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			socket_source_port_r <= `SOURCE_PORT_RESET;
			mode_r               <= 4'h0;
			socket_dest_ip_r     <= 32'h0000_0000;
		end else if (wr_en) begin
			if (widx == `IDX_SOURCE_PORT) begin
				// Bits 15:8 are the byte at the lower address
				socket_source_port_r <= apb_req.pwdata[15:0];
			end else if (widx == `IDX_MODE) begin
				mode_r <= apb_req.pwdata[3:0];
			end else if (widx == `IDX_DEST_IP) begin
				socket_dest_ip_r <= apb_req.pwdata;
			end
		end
	end

	// ==========================================================
	// Interrupt flags, write one to clear; hardware set wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			socket_interrupt_flags_r <= 8'h00;
		end else begin
			for (int i = 0; i < 8; i++) begin
				if ((i == `INT_TIMEOUT_BIT && timeout_set) || (i == `INT_CON_BIT && con_set)
				    || (i == `INT_DISCON_BIT && discon_set)) begin
					socket_interrupt_flags_r[i] <= 1'b1;
				end else if (wr_en && widx == `IDX_INT_FLAGS && apb_req.pwdata[i]) begin
					socket_interrupt_flags_r[i] <= 1'b0;
				end
			end
		end
	end

	// ==========================================================
	// Next state
	always_comb begin
		state_nxt   = state_r;
		timeout_set = 1'b0;
		con_set     = 1'b0;
		discon_set  = 1'b0;
		case (state_r)
			st_released: begin
				if (cmd_valid && cmd == `CMD_OPEN) begin
					if (mode_r == `MODE_TCP) begin
						state_nxt = st_tcp_opened;
					end else if (mode_r == `MODE_UDP) begin
						state_nxt = st_datagram;
					end else if (mode_r == `MODE_IPRAW) begin
						state_nxt = st_raw_ip;
					end
				end
			end
			st_tcp_opened: begin
				if (cmd_valid && cmd == `CMD_LISTEN) begin
					state_nxt = st_listen;
				end else if (cmd_valid && cmd == `CMD_CONNECT) begin
					state_nxt = st_arp;
				end
			end
			st_listen: begin
				if (net_event[`EV_SYN_RX]) begin
					state_nxt = st_req_recv;
				end
			end
			st_req_sent: begin
				if (net_event[`EV_SYNACK_RX]) begin
					state_nxt = st_connected;
					con_set   = 1'b1;
				end else if (net_event[`EV_TCP_TIMEOUT]) begin
					state_nxt   = st_released;
					timeout_set = 1'b1;
				end
			end
			st_req_recv: begin
				if (net_event[`EV_SYNACK_TX_DONE]) begin
					state_nxt = st_connected;
					con_set   = 1'b1;
				end else if (net_event[`EV_ACCEPT_FAIL] || net_event[`EV_TCP_TIMEOUT]) begin
					state_nxt   = st_released;
					timeout_set = 1'b1;
				end
			end
			st_connected: begin
				if (cmd_valid && cmd == `CMD_DISCON) begin
					state_nxt = st_closing_wait;
				end else if (net_event[`EV_FIN_RX]) begin
					state_nxt  = st_close_wait;
					discon_set = 1'b1;
				end
			end
			st_close_wait: begin
				if (cmd_valid && cmd == `CMD_DISCON) begin
					state_nxt = st_final_ack;
				end
			end
			st_closing_wait: begin
				if (net_event[`EV_FIN_RX]) begin
					state_nxt  = st_linger;
					discon_set = 1'b1;
				end
			end
			st_linger: begin
				if (linger_cnt_r == 16'(LINGER_CYCLES - 1)) begin
					state_nxt = st_released;
				end
			end
			st_final_ack: begin
				if (net_event[`EV_DISCON_DONE] || net_event[`EV_FIN_SENT_ACKED]) begin
					state_nxt = st_released;
				end
			end
			st_arp: begin
				// Origin kept on entry, so both exits know where to go
				if (net_event[`EV_ARP_REPLY]) begin
					state_nxt = (arp_return_r == st_tcp_opened) ? st_req_sent : arp_return_r;
				end else if (net_event[`EV_ARP_TIMEOUT]) begin
					timeout_set = 1'b1;
					state_nxt   = (arp_return_r == st_tcp_opened) ? st_released : arp_return_r;
				end
			end
			st_datagram, st_raw_ip: begin
				if (cmd_valid && cmd == `CMD_SEND
				    && (!resolved_valid_r || resolved_ip_r != socket_dest_ip_r)) begin
					state_nxt = st_arp;
				end
			end
			default: state_nxt = st_released;
		endcase
		// Common exits from the closing-wait, linger and final-ack states (not close-wait)
		if (state_r inside {st_closing_wait, st_linger, st_final_ack}
		    && (net_event[`EV_TCP_TIMEOUT] || net_event[`EV_DISCON_DONE])) begin
			state_nxt   = st_released;
			timeout_set = net_event[`EV_TCP_TIMEOUT];
		end
		if (cmd_valid && cmd == `CMD_CLOSE) begin
			state_nxt = st_released;
		end
	end

	// ==========================================================
	// State registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r      <= st_released;
			arp_return_r <= st_released;
		end else begin
			state_r <= state_nxt;
			if (state_r != st_arp && state_nxt == st_arp)
				arp_return_r <= state_r;
		end
	end

	// ==========================================================
	// Linger timer, counts only while lingering
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			linger_cnt_r <= 16'h0000;
		end else if (state_r == st_linger) begin
			linger_cnt_r <= linger_cnt_r + 16'h0001;
		end else begin
			linger_cnt_r <= 16'h0000;
		end
	end

	// ==========================================================
	// Resolution cache
	// A new IP forces a fresh lookup
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			resolved_ip_r    <= 32'h0000_0000;
			resolved_valid_r <= 1'b0;
		end else if (state_r == st_arp && net_event[`EV_ARP_REPLY]) begin
			resolved_ip_r    <= socket_dest_ip_r;
			resolved_valid_r <= 1'b1;
		end else if (state_nxt == st_released) begin
			resolved_valid_r <= 1'b0;
		end
	end

	// ==========================================================
	// Actions toward the network side
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			net_action <= '0;
		end else begin
			net_action.arp_request <= (state_r != st_arp) && (state_nxt == st_arp);
			net_action.syn_tx      <= (state_r != st_req_sent) && (state_nxt == st_req_sent);
			net_action.synack_tx   <= (state_r != st_req_recv) && (state_nxt == st_req_recv);
			net_action.fin_tx      <= (state_nxt == st_closing_wait || state_nxt == st_final_ack)
			                          && (state_r != state_nxt);
			// Port only meaningful for TCP or UDP sockets
			net_action.port_valid  <= port_in_use(mode_r);
		end
	end

	// ==========================================================
	// Source port toward the network side
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			source_port_out <= 16'h0000;
		end else begin
			// Raw IP sees zero so a stale port never leaks out
			source_port_out <= port_in_use(mode_r) ? socket_source_port_r : 16'h0000;
		end
	end

endmodule : sock_fsm
`default_nettype wire

// ===== testbench/sock_fsm_properties.sv
// Port relation checker for the socket state block
`timescale 1ns/1ps
`default_nettype none
`include "sock_fsm_params.svh"
module sock_fsm_properties
	import sock_fsm_pkg::*;
#(
	parameter int LINGER_CYCLES = 4
) (
	input wire logic                  pclk,
	input wire logic                  presetn,
	input wire apb_req_t              apb_req,
	input wire apb_rsp_t              apb_rsp,
	input wire logic [`EV_WIDTH-1:0]  net_event,
	input wire net_action_t           net_action,
	input wire logic [15:0]           source_port_out
);
	// ==========================================================
	// Bus and action relations
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	chk_ready_after_setup: assert property (apb_req.psel && !apb_req.penable |=> apb_rsp.pready)
		else $error("no ready after setup");
	chk_ready_one_cycle: assert property (apb_rsp.pready |=> !apb_rsp.pready)
		else $error("ready held too long");
	chk_idle_quiet: assert property (!apb_req.psel |=> !apb_rsp.pready)
		else $error("ready without select");
	chk_unmapped_err: assert property (apb_req.psel && apb_req.penable && apb_rsp.pready
		&& apb_req.paddr == 18'h3fffc |-> apb_rsp.pslverr && apb_rsp.prdata == 32'h0)
		else $error("unmapped access not refused");
	chk_state_read_ok: assert property (apb_req.psel && apb_req.penable && apb_rsp.pready
		&& apb_req.paddr == `ADDR_OF(`IDX_STATE_CODE) |-> !apb_rsp.pslverr && apb_rsp.prdata[31:8] == 24'h0)
		else $error("state code access faulty");
	chk_err_with_ready: assert property (apb_rsp.pslverr |-> apb_rsp.pready)
		else $error("error flag outside access");
	chk_port_masked: assert property (!net_action.port_valid |-> source_port_out == 16'h0000)
		else $error("port used outside tcp or udp");
	chk_arp_pulse: assert property (net_action.arp_request |=> !net_action.arp_request)
		else $error("resolution request not a pulse");
	chk_syn_cause: assert property ($rose(net_action.syn_tx) |-> $past(net_event[`EV_ARP_REPLY], 1)
		|| $past(net_event[`EV_ARP_REPLY], 2) || $past(net_event[`EV_ARP_REPLY], 3))
		else $error("request sent without resolution reply");
	chk_accept_cause: assert property ($rose(net_action.synack_tx) |-> $past(net_event[`EV_SYN_RX], 1)
		|| $past(net_event[`EV_SYN_RX], 2) || $past(net_event[`EV_SYN_RX], 3))
		else $error("accept sent without request");
endmodule : sock_fsm_properties
bind sock_fsm sock_fsm_properties #(.LINGER_CYCLES(LINGER_CYCLES)) i_chk (.pclk(pclk), .presetn(presetn),
	.apb_req(apb_req), .apb_rsp(apb_rsp), .net_event(net_event), .net_action(net_action),
	.source_port_out(source_port_out));
`default_nettype wire

// ===== testbench/remote_peer.sv
// Remote network peer answering the socket block
`timescale 1ns/1ps
`default_nettype none
`include "sock_fsm_params.svh"
module remote_peer
	import sock_fsm_pkg::*;
(
	input  wire logic                 pclk,
	input  wire logic                 presetn,
	input  wire net_action_t          net_action,
	input  wire logic [4:0]           lag,
	input  wire logic                 arp_ok,
	input  wire logic                 syn_ok,
	input  wire logic                 acc_ok,
	input  wire logic                 fin_ack,
	output logic [`EV_WIDTH-1:0]      peer_ev
);
	logic [4:0]           cnt_r;
	logic [`EV_WIDTH-1:0] pend_r;
	function automatic logic [`EV_WIDTH-1:0] one(input int b);
		return `EV_WIDTH'(1) << b;
	endfunction : one
	// ==========================================================
	// One answer in flight, given out lag+1 cycles after it is taken
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_r   <= '0;
			pend_r  <= '0;
			peer_ev <= '0;
		end else begin
			peer_ev <= '0;
			if (pend_r != '0) begin
				if (cnt_r == 5'd0) begin
					peer_ev <= pend_r;
					pend_r  <= '0;
				end else begin
					cnt_r <= cnt_r - 5'd1;
				end
			end else begin
				cnt_r <= lag;
				if (net_action.arp_request)
					pend_r <= one(arp_ok ? `EV_ARP_REPLY : `EV_ARP_TIMEOUT);
				else if (net_action.syn_tx)
					pend_r <= one(syn_ok ? `EV_SYNACK_RX : `EV_TCP_TIMEOUT);
				else if (net_action.synack_tx)
					pend_r <= one(acc_ok ? `EV_SYNACK_TX_DONE : `EV_ACCEPT_FAIL);
				else if (net_action.fin_tx && fin_ack)
					pend_r <= one(`EV_FIN_SENT_ACKED);
			end
		end
	end
endmodule : remote_peer
`default_nettype wire

// ===== testbench/socket_transient_state_machine_tb_top.sv
// Self-checking bench of the socket state block
`timescale 1ns/1ps
`default_nettype none
`include "sock_fsm_params.svh"
module socket_transient_state_machine_tb_top;
	import sock_fsm_pkg::*;
	logic                 pclk;
	logic                 presetn;
	apb_req_t             apb_req;
	apb_rsp_t             apb_rsp;
	logic [`EV_WIDTH-1:0] net_event, peer_ev, tb_ev;
	net_action_t          net_action;
	logic [15:0]          source_port_out, port;
	logic [4:0]           lag;
	logic                 arp_ok, syn_ok, acc_ok, fin_ack, e;
	logic [31:0]          r;
	logic [3:0]           modes [3] = '{`MODE_TCP, `MODE_UDP, `MODE_IPRAW};
	int                   fail_count = 0, checks_done = 0, cyc = 0;
	assign net_event = peer_ev | tb_ev;
	sock_fsm #(.LINGER_CYCLES(40)) i_dut (.pclk(pclk), .presetn(presetn), .apb_req(apb_req),
		.apb_rsp(apb_rsp), .net_event(net_event), .net_action(net_action),
		.source_port_out(source_port_out));
	remote_peer i_peer (.pclk(pclk), .presetn(presetn), .net_action(net_action), .lag(lag),
		.arp_ok(arp_ok), .syn_ok(syn_ok), .acc_ok(acc_ok), .fin_ack(fin_ack), .peer_ev(peer_ev));
	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end
	// ==========================================================
	// Helpers
	task report_and_stop();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : report_and_stop
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			fail_count++;
			report_and_stop();
		end
	end
	task chk(input logic [31:0] g, input logic [31:0] x);
		checks_done++;
		if (g !== x) begin
			fail_count++;
			$display("wrong value at %0t: got %h expected %h", $time, g, x);
		end
	endtask : chk
	// Leaves one idle cycle between transfers so no signal is driven twice in a step
	task apb(input logic w, input logic [17:0] a, input logic [31:0] d);
		@(posedge pclk);
		apb_req <= '{1'b1, 1'b0, w, a, d};
		@(posedge pclk);
		apb_req.penable <= 1'b1;
		// No wait count assumed; only the cycle ceiling ends a hang
		do begin
			@(posedge pclk);
		end while (apb_rsp.pready !== 1'b1);
		r = apb_rsp.prdata;
		e = apb_rsp.pslverr;
		apb_req <= '0;
	endtask : apb
	task cmd(input logic [7:0] c);
		apb(1'b1, `ADDR_OF(`IDX_COMMAND), {24'h0, c});
	endtask : cmd
	// Polls because transient codes last only as long as the peer delays
	task code(input logic [7:0] x);
		int n;
		n = 0;
		do begin
			apb(1'b0, `ADDR_OF(`IDX_STATE_CODE), 32'h0);
			n++;
		end while (r[7:0] !== x && n < 60);
		chk(r, {24'h0, x});
	endtask : code
	task flag(input logic x);
		apb(1'b0, `ADDR_OF(`IDX_INT_FLAGS), 32'h0);
		chk(r[`INT_TIMEOUT_BIT], x);
		apb(1'b1, `ADDR_OF(`IDX_INT_FLAGS), 32'hff);
	endtask : flag
	task pulse(input int b);
		@(posedge pclk);
		tb_ev[b] <= 1'b1;
		@(posedge pclk);
		tb_ev[b] <= 1'b0;
	endtask : pulse
	task open(input logic [3:0] m);
		lag <= 5'd10 + 5'($urandom % 16);
		port = 16'($urandom);
		apb(1'b1, `ADDR_OF(`IDX_MODE), {28'h0, m});
		apb(1'b1, `ADDR_OF(`IDX_SOURCE_PORT), {16'h0, port});
		cmd(`CMD_OPEN);
	endtask : open
	function automatic logic [7:0] exp_code(input logic [3:0] m);
		return m == `MODE_TCP ? `CODE_TCP_OPENED : m == `MODE_UDP ? `CODE_DATAGRAM : `CODE_RAW_IP;
	endfunction : exp_code
	function automatic logic [15:0] exp_port(input logic [3:0] m, input logic [15:0] p);
		return (m == `MODE_TCP || m == `MODE_UDP) ? p : 16'h0000;
	endfunction : exp_port
	// ==========================================================
	// Scenarios
	initial begin
		apb_req = '0;
		tb_ev = '0;
		presetn = 1'b0;
		lag = 5'd10;
		{arp_ok, syn_ok, acc_ok, fin_ack} = 4'hf;
		fin_ack = 1'b0;
		void'($urandom(22));
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, `ADDR_OF(`IDX_SOURCE_PORT), 32'h0);
		chk(r, 32'h0);
		code(`CODE_RELEASED);
		apb(1'b0, 18'h3fffc, 32'h0);
		chk(e, 1'b1);
		apb(1'b1, `ADDR_OF(`IDX_STATE_CODE), 32'h55);
		chk(e, 1'b0);
		code(`CODE_RELEASED);
		for (int i = 0; i < 3; i++) begin
			open(modes[i]);
			code(exp_code(modes[i]));
			chk(source_port_out, exp_port(modes[i], port));
			apb(1'b0, `ADDR_OF(`IDX_SOURCE_PORT), 32'h0);
			chk(r, {16'h0, port});
			cmd(`CMD_CLOSE);
		end
		for (int k = 0; k < 3; k++) begin
			arp_ok <= k != 1;
			syn_ok <= k != 2;
			open(`MODE_TCP);
			cmd(`CMD_CONNECT);
			code(`CODE_ARP);
			if (k != 1)
				code(`CODE_REQ_SENT);
			code(k == 0 ? `CODE_CONNECTED : `CODE_RELEASED);
			flag(k != 0);
			if (k == 0) begin
				cmd(`CMD_DISCON);
				code(`CODE_CLOSING_WAIT);
				pulse(`EV_FIN_RX);
				code(`CODE_LINGER);
				code(`CODE_RELEASED);
			end
			cmd(`CMD_CLOSE);
		end
		for (int k = 0; k < 2; k++) begin
			acc_ok <= k == 0;
			open(`MODE_TCP);
			cmd(`CMD_LISTEN);
			pulse(`EV_SYN_RX);
			code(`CODE_REQ_RECV);
			code(k == 0 ? `CODE_CONNECTED : `CODE_RELEASED);
			flag(k == 1);
			if (k == 0) begin
				pulse(`EV_FIN_RX);
				code(`CODE_CLOSE_WAIT);
				fin_ack <= 1'b1;
				cmd(`CMD_DISCON);
				code(`CODE_FINAL_ACK);
				code(`CODE_RELEASED);
				fin_ack <= 1'b0;
			end
			cmd(`CMD_CLOSE);
		end
		for (int i = 1; i < 3; i++) begin
			arp_ok <= 1'b1;
			open(modes[i]);
			apb(1'b1, `ADDR_OF(`IDX_DEST_IP), $urandom);
			cmd(`CMD_SEND);
			code(`CODE_ARP);
			code(exp_code(modes[i]));
			cmd(`CMD_SEND);
			apb(1'b0, `ADDR_OF(`IDX_STATE_CODE), 32'h0);
			chk(r[7:0], exp_code(modes[i]));
			arp_ok <= 1'b0;
			apb(1'b1, `ADDR_OF(`IDX_DEST_IP), ~r);
			cmd(`CMD_SEND);
			code(`CODE_ARP);
			code(exp_code(modes[i]));
			flag(1'b1);
			cmd(`CMD_CLOSE);
		end
		report_and_stop();
	end
endmodule : socket_transient_state_machine_tb_top
`default_nettype wire
